// *** rtl/lif_pkg.sv ***
// Purpose: Shared constants and types for the line interface status bank.
// Assumes: 32-bit AXI4-Lite data; register index times four is the byte address.
// Notes: Loss figures are kept in half-dB units so that 22.5 and 17.5 stay exact.
package lif_pkg;
   localparam int unsigned LIF_ADDR_W = 16;
   localparam logic [15:0] LIF_IDX_MASK = 16'h1004;
   localparam logic [15:0] LIF_IDX_LATCH = 16'h1005;
   localparam logic [15:0] LIF_IDX_LEVEL = 16'h1006;
   localparam logic [15:0] LIF_IDX_RXCFG = 16'h1007;
   localparam logic [7:0] LIF_RST_BYTE = 8'h00;
   localparam logic [31:0] LIF_RST_WORD = 32'h0000_0000;
   localparam logic [1:0] LIF_RESP_OKAY = 2'h0;
   localparam logic [1:0] LIF_RESP_SLVERR = 2'h2;
   localparam int unsigned LIF_ENDED_OFS = 4;
   localparam int unsigned LIF_LEVEL_LSB = 4;
   localparam int unsigned LIF_CFG_CLKIN = 7;
   localparam int unsigned LIF_CFG_TERM_OFF = 6;
   localparam int unsigned LIF_CFG_IMP_LSB = 4;
   localparam int unsigned LIF_CFG_RATIO = 3;
   localparam int unsigned LIF_CFG_MON = 2;
   localparam int unsigned LIF_CFG_SENS_LSB = 0;
   localparam logic [3:0] LIF_LVL_MAX_T1 = 4'hD;
   localparam logic [3:0] LIF_LVL_MAX_E1 = 4'hF;
   localparam logic [2:0] LIF_LBO_CSU_MIN = 3'h5;
   localparam logic [7:0] LIF_OHM_75 = 8'h4B;
   localparam logic [7:0] LIF_OHM_100 = 8'h64;
   localparam logic [7:0] LIF_OHM_110 = 8'h6E;
   localparam logic [7:0] LIF_OHM_120 = 8'h78;
   localparam logic [11:0] LIF_KHZ_T1 = 12'h608;
   localparam logic [11:0] LIF_KHZ_E1 = 12'h800;
   localparam logic [5:0] LIF_GAIN_0 = 6'h00;
   localparam logic [5:0] LIF_GAIN_14 = 6'h0E;
   localparam logic [5:0] LIF_GAIN_20 = 6'h14;
   localparam logic [5:0] LIF_GAIN_26 = 6'h1A;
   localparam logic [5:0] LIF_GAIN_32 = 6'h20;
   localparam logic [6:0] LIF_HDB_12 = 7'h18;
   localparam logic [6:0] LIF_HDB_17P5 = 7'h23;
   localparam logic [6:0] LIF_HDB_18 = 7'h24;
   localparam logic [6:0] LIF_HDB_22P5 = 7'h2D;
   localparam logic [6:0] LIF_HDB_30 = 7'h3C;
   localparam logic [6:0] LIF_HDB_36 = 7'h48;
   localparam logic [6:0] LIF_HDB_43 = 7'h56;

   typedef enum logic [2:0] {
      LIF_SEL_NONE,
      LIF_SEL_MASK,
      LIF_SEL_LATCH,
      LIF_SEL_LEVEL,
      LIF_SEL_RXCFG
   } lif_sel_t;

   typedef struct packed {
      logic limit_trip;
      logic open_circuit;
      logic short_circuit;
      logic signal_loss;
   } lif_cond_t;

   typedef struct packed {
      logic rx_clock_input_mode;
      logic [11:0] clock_khz;
      logic termination_en;
      logic [7:0] impedance_ohm;
      logic turns_2to1;
      logic rx_monitor_enable;
      logic [5:0] monitor_gain_db;
      logic [6:0] max_loss_half_db;
   } lif_rxcfg_t;
endpackage : lif_pkg

// *** rtl/lif_status_bank.sv ***
// Purpose: Line interface event latches, mask, level report and receive setup.
// Assumes: Detector inputs are synchronous to clk_i; one AXI4-Lite master.
// Notes: The interrupt output is registered and trails the latch by one cycle.
// Behaviour
// - Mask bits 3..0 enable onset interrupts.
// - Latched bits hold and may interrupt.
// - Bit 7 sets when limit trip ends.
// - Bits 6,5 set when open/short end.
// - Bit 4 sets when signal loss ends.
// - Bit 3 sets at limit trip onset.
// - Bits 2,1 onset; blocked in CSU build-outs.
// - Bit 0 sets at signal loss onset.
// - Level code in bits 7..4, capped per standard.
// - Short haul caps level at equalizer limit.
// - Clock input mode expects line-rate clock.
// - Bit 6 set disables receive termination.
// - Bits 5..4 pick 75/100/110/120 ohms.
// - Bit 3 picks 1:1 or 2:1 ratio.
// - Bit 2 enables monitor mode gain.
// - Monitor off: no gain, 12..36/43 dB.
// - Monitor on: 14..32 dB gain, reduced loss.
// - Standard select chooses E1 or T1/J1.
// - Mask bits 7..4 enable end interrupts.
`timescale 1ns/10ps
module lif_status_bank (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic [lif_pkg::LIF_ADDR_W-1:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [lif_pkg::LIF_ADDR_W-1:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire lif_pkg::lif_cond_t line_cond_i,
   input wire logic [3:0] level_code_i,
   input wire logic [3:0] equalizer_gain_cap_i,
   input wire logic short_haul_i,
   input wire logic line_standard_select_i,
   input wire logic [2:0] tx_build_out_code_i,
   output lif_pkg::lif_rxcfg_t rx_cfg_o,
   output logic irq_o
);
   import lif_pkg::*;

   function automatic lif_sel_t reg_sel(input logic [LIF_ADDR_W-1:0] a);
      lif_sel_t s;
      s = LIF_SEL_NONE;
      if (a[1:0] == 2'h0) begin
         case (a[LIF_ADDR_W-1:2])
            LIF_IDX_MASK[LIF_ADDR_W-3:0]: s = LIF_SEL_MASK;
            LIF_IDX_LATCH[LIF_ADDR_W-3:0]: s = LIF_SEL_LATCH;
            LIF_IDX_LEVEL[LIF_ADDR_W-3:0]: s = LIF_SEL_LEVEL;
            LIF_IDX_RXCFG[LIF_ADDR_W-3:0]: s = LIF_SEL_RXCFG;
            default: s = LIF_SEL_NONE;
         endcase
      end
      return s;
   endfunction : reg_sel

   function automatic logic [7:0] imp_ohm(input logic [1:0] c);
      logic [7:0] v;
      case (c)
         2'h0: v = LIF_OHM_75;
         2'h1: v = LIF_OHM_100;
         2'h2: v = LIF_OHM_110;
         default: v = LIF_OHM_120;
      endcase
      return v;
   endfunction : imp_ohm

   function automatic logic [5:0] mon_gain(input logic mon, input logic [1:0] c);
      logic [5:0] v;
      case ({mon, c})
         3'h4: v = LIF_GAIN_14;
         3'h5: v = LIF_GAIN_20;
         3'h6: v = LIF_GAIN_26;
         3'h7: v = LIF_GAIN_32;
         default: v = LIF_GAIN_0;
      endcase
      return v;
   endfunction : mon_gain

   function automatic logic [6:0] max_loss(input logic mon, input logic [1:0] c, input logic t1);
      logic [6:0] v;
      case ({mon, c})
         3'h0: v = LIF_HDB_12;
         3'h1: v = LIF_HDB_18;
         3'h2: v = LIF_HDB_30;
         3'h3: v = t1 ? LIF_HDB_36 : LIF_HDB_43;
         3'h4: v = LIF_HDB_30;
         3'h5: v = LIF_HDB_22P5;
         3'h6: v = LIF_HDB_17P5;
         default: v = LIF_HDB_12;
      endcase
      return v;
   endfunction : max_loss

   logic [7:0] mask_q, mask_d;
   logic [7:0] latched_q, latched_d;
   logic [7:0] level_q, level_d;
   logic [7:0] rxcfg_q, rxcfg_d;
   lif_cond_t prev_q;
   lif_rxcfg_t cfg_q, cfg_d;
   logic irq_q;
   logic aw_held_q, aw_held_d;
   logic w_held_q, w_held_d;
   logic [LIF_ADDR_W-1:0] awaddr_q, awaddr_d;
   logic [7:0] wdata_q, wdata_d;
   logic wstrb0_q, wstrb0_d;
   logic bvalid_q, bvalid_d;
   logic [1:0] bresp_q, bresp_d;
   logic rvalid_q, rvalid_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0] rresp_q, rresp_d;

   // Write path: address and data are caught separately, in either order.
   wire aw_fire = s_axi_awvalid_i && s_axi_awready_o;
   wire w_fire = s_axi_wvalid_i && s_axi_wready_o;
   wire wr_go = aw_held_q && w_held_q && !bvalid_q;
   wire lif_sel_t wr_sel = reg_sel(awaddr_q);
   wire wr_en = wr_go && wstrb0_q;
   wire ar_fire = s_axi_arvalid_i && s_axi_arready_o;
   wire lif_sel_t rd_sel = reg_sel(s_axi_araddr_i);

   assign s_axi_awready_o = !aw_held_q && !bvalid_q;
   assign s_axi_wready_o = !w_held_q && !bvalid_q;
   assign s_axi_arready_o = !rvalid_q;
   assign aw_held_d = wr_go ? 1'b0 : (aw_fire ? 1'b1 : aw_held_q);
   assign w_held_d = wr_go ? 1'b0 : (w_fire ? 1'b1 : w_held_q);
   assign awaddr_d = aw_fire ? s_axi_awaddr_i : awaddr_q;
   assign wdata_d = w_fire ? s_axi_wdata_i[7:0] : wdata_q;
   assign wstrb0_d = w_fire ? s_axi_wstrb_i[0] : wstrb0_q;
   assign bvalid_d = wr_go ? 1'b1 : (s_axi_bready_i ? 1'b0 : bvalid_q);
   assign bresp_d = wr_go ? ((wr_sel == LIF_SEL_NONE) ? LIF_RESP_SLVERR : LIF_RESP_OKAY) : bresp_q;

   assign mask_d = (wr_en && wr_sel == LIF_SEL_MASK) ? wdata_q : mask_q;

   assign rxcfg_d = (wr_en && wr_sel == LIF_SEL_RXCFG) ? wdata_q : rxcfg_q;

   // Event detection against the previous cycle's detector levels.
   wire lif_cond_t rise = line_cond_i & ~prev_q;
   wire lif_cond_t fall = ~line_cond_i & prev_q;

   // CSU build-outs only exist in T1 mode.
   // Standard select gates the CSU test.
   wire csu_mode = line_standard_select_i && (tx_build_out_code_i >= LIF_LBO_CSU_MIN);

   wire [3:0] began = {rise.limit_trip, rise.open_circuit && !csu_mode,
                       rise.short_circuit && !csu_mode, rise.signal_loss};

   wire [3:0] ended = fall;
   wire [7:0] ev_set = {ended, began};
   wire [7:0] ev_clr = (wr_en && wr_sel == LIF_SEL_LATCH) ? wdata_q : LIF_RST_BYTE;

   assign latched_d = (latched_q & ~ev_clr) | ev_set;

   // Cap the level code per standard.
   // Short haul obeys the equalizer cap.
   wire [3:0] std_cap = line_standard_select_i ? LIF_LVL_MAX_T1 : LIF_LVL_MAX_E1;
   wire [3:0] lvl_cap = (short_haul_i && equalizer_gain_cap_i < std_cap) ? equalizer_gain_cap_i : std_cap;
   wire [3:0] lvl_code = (level_code_i > lvl_cap) ? lvl_cap : level_code_i;
   assign level_d = {lvl_code, 4'h0};

   assign cfg_d.rx_clock_input_mode = rxcfg_q[LIF_CFG_CLKIN];
   assign cfg_d.clock_khz = line_standard_select_i ? LIF_KHZ_T1 : LIF_KHZ_E1;
   // Termination is active when the off bit is clear.
   assign cfg_d.termination_en = !rxcfg_q[LIF_CFG_TERM_OFF];
   // Impedance decode holds even with termination off.
   assign cfg_d.impedance_ohm = imp_ohm(rxcfg_q[LIF_CFG_IMP_LSB+:2]);
   assign cfg_d.turns_2to1 = rxcfg_q[LIF_CFG_RATIO];
   assign cfg_d.rx_monitor_enable = rxcfg_q[LIF_CFG_MON];
   assign cfg_d.monitor_gain_db = mon_gain(rxcfg_q[LIF_CFG_MON], rxcfg_q[LIF_CFG_SENS_LSB+:2]);
   assign cfg_d.max_loss_half_db = max_loss(rxcfg_q[LIF_CFG_MON], rxcfg_q[LIF_CFG_SENS_LSB+:2],
                                            line_standard_select_i);

   // Reads have no side effects; the latched bits clear only by write.
   always_comb begin
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      if (ar_fire) begin
         rdata_d = LIF_RST_WORD;
         rresp_d = LIF_RESP_OKAY;
         case (rd_sel)
            LIF_SEL_MASK: rdata_d[7:0] = mask_q;
            LIF_SEL_LATCH: rdata_d[7:0] = latched_q;
            LIF_SEL_LEVEL: rdata_d[7:0] = level_q;
            LIF_SEL_RXCFG: rdata_d[7:0] = rxcfg_q;
            default: rresp_d = LIF_RESP_SLVERR;
         endcase
      end
   end
   assign rvalid_d = ar_fire ? 1'b1 : (s_axi_rready_i ? 1'b0 : rvalid_q);

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= LIF_RST_BYTE;
         wstrb0_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= LIF_RESP_OKAY;
         rvalid_q <= 1'b0;
         rdata_q <= LIF_RST_WORD;
         rresp_q <= LIF_RESP_OKAY;
      end else begin
         aw_held_q <= aw_held_d;
         w_held_q <= w_held_d;
         awaddr_q <= awaddr_d;
         wdata_q <= wdata_d;
         wstrb0_q <= wstrb0_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
      end
   end

   // The detector history resets to idle, so a condition already present
   // at release is reported as an onset on the first edge.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mask_q <= LIF_RST_BYTE;
         latched_q <= LIF_RST_BYTE;
         level_q <= LIF_RST_BYTE;
         rxcfg_q <= LIF_RST_BYTE;
         prev_q <= '0;
         cfg_q <= '0;
         irq_q <= 1'b0;
      end else begin
         mask_q <= mask_d;
         latched_q <= latched_d;
         level_q <= level_d;
         rxcfg_q <= rxcfg_d;
         prev_q <= line_cond_i;
         cfg_q <= cfg_d;
         irq_q <= |(latched_q & mask_q);
      end
   end

   assign s_axi_bvalid_o = bvalid_q;
   assign s_axi_bresp_o = bresp_q;
   assign s_axi_rvalid_o = rvalid_q;
   assign s_axi_rdata_o = rdata_q;
   assign s_axi_rresp_o = rresp_q;
   assign rx_cfg_o = cfg_q;
   assign irq_o = irq_q;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i);

   sequence s_mask_enable;
      wr_en && wr_sel == LIF_SEL_MASK && ((wdata_q & latched_q) != 8'h00) && ev_clr == 8'h00;
   endsequence

   sequence s_clear_all;
      wr_en && wr_sel == LIF_SEL_LATCH && wdata_q == 8'hFF && ev_set == 8'h00;
   endsequence

   sequence s_quiet;
      ev_set == 8'h00 && ev_clr == 8'h00;
   endsequence

   chk_loss_onset: assert property (rise.signal_loss |=> latched_q[0])
      else $error("Signal loss onset not latched.");
   chk_loss_end: assert property (fall.signal_loss |=> latched_q[4])
      else $error("Signal loss end not latched.");
   chk_trip_onset: assert property (rise.limit_trip |=> latched_q[3])
      else $error("Limit trip onset not latched.");
   chk_trip_end: assert property ($fell(line_cond_i.limit_trip) |=> latched_q[7])
      else $error("Limit trip end not latched.");
   chk_open_end: assert property (fall.open_circuit |=> latched_q[6])
      else $error("Open end not latched.");
   chk_short_end: assert property (fall.short_circuit |=> latched_q[5])
      else $error("Short end not latched.");
   chk_csu_block: assert property (csu_mode && !latched_q[2] |=> !latched_q[2])
      else $error("Open onset latched in a CSU build-out.");
   chk_set_wins: assert property (ev_set[0] && ev_clr[0] |=> latched_q[0])
      else $error("Clear overrode a same-cycle event.");
   chk_hold_bits: assert property (s_quiet |=> latched_q == $past(latched_q))
      else $error("Latched bits changed without cause.");
   chk_irq_raise: assert property (s_mask_enable |=> ##1 irq_o)
      else $error("Interrupt not raised after mask enable.");
   chk_irq_drop: assert property (s_clear_all ##1 s_quiet |=> !irq_o)
      else $error("Interrupt not dropped after full clear.");
   chk_mask_store: assert property (wr_en && wr_sel == LIF_SEL_MASK |=> mask_q == $past(wdata_q))
      else $error("Mask write not stored.");
   chk_level_cap: assert property (1'b1 |=> level_q[7:4] <= $past(lvl_cap) && level_q[3:0] == 4'h0)
      else $error("Level code exceeds its cap.");
   chk_level_t1: assert property (line_standard_select_i && !short_haul_i |=> level_q[7:4] <= LIF_LVL_MAX_T1)
      else $error("T1 level code above its top code.");
   chk_mon_off: assert property (!rxcfg_q[LIF_CFG_MON] |=> cfg_q.monitor_gain_db == LIF_GAIN_0)
      else $error("Gain present with monitor off.");
   chk_mon_on: assert property (rxcfg_q[LIF_CFG_MON] && rxcfg_q[1:0] == 2'h1 |=> cfg_q.max_loss_half_db == LIF_HDB_22P5)
      else $error("Monitor loss figure wrong.");
   chk_term_off: assert property (wr_en && wr_sel == LIF_SEL_RXCFG |=> ##1 cfg_q.termination_en == !$past(wdata_q[6], 2))
      else $error("Termination enable does not follow setup.");
   chk_clock_rate: assert property (line_standard_select_i |=> cfg_q.clock_khz == LIF_KHZ_T1)
      else $error("Expected clock rate wrong for T1.");
   chk_write_resp: assert property (aw_fire && w_fire |=> ##1 s_axi_bvalid_o)
      else $error("Write response late.");
endmodule : lif_status_bank

// *** testbench/lif_line_model.sv ***
// Purpose: Line front end stand-in that drives the detector and level outputs.
// Assumes: Requests come from the bench, synchronous to clk_i.
// Notes: Outputs are registered, so every requested change lands one cycle late.
`timescale 1ns/10ps
module lif_line_model (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire lif_pkg::lif_cond_t cond_req_i,
   input wire logic [3:0] level_req_i,
   output lif_pkg::lif_cond_t cond_o,
   output logic [3:0] level_o
);
   import lif_pkg::*;
   // Detectors are powered down in reset, so they report no condition.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cond_o <= '0;
         level_o <= 4'h0;
      end else begin
         cond_o <= cond_req_i;
         level_o <= level_req_i;
      end
   end
endmodule : lif_line_model

// *** testbench/testbench.sv ***
// Purpose: Self-checking bench for the line interface status bank.
// Assumes: Tasks are entered just after a rising edge of clk_i.
// Notes: Expected latch, mask and level values come from a model kept here.
`timescale 1ns/10ps
module testbench;
   import lif_pkg::*;
   localparam logic [15:0] A_MASK = {LIF_IDX_MASK[13:0], 2'b00};
   localparam logic [15:0] A_LAT = {LIF_IDX_LATCH[13:0], 2'b00};
   localparam logic [15:0] A_LVL = {LIF_IDX_LEVEL[13:0], 2'b00};
   localparam logic [15:0] A_CFG = {LIF_IDX_RXCFG[13:0], 2'b00};
   logic clk_i, resetn_i, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, irq, short_haul, std_sel;
   logic [15:0] awaddr, araddr;
   logic [31:0] wdata, rdata, seed;
   logic [3:0] wstrb, lvl_req, lvl, eq_cap;
   logic [1:0] bresp, rresp;
   logic [2:0] tx_build_out_code;
   logic [7:0] m_lat, m_mask;
   lif_cond_t cond_req, cond;
   lif_rxcfg_t rx_cfg;
   int error_cnt, compares, cycles;

   lif_status_bank u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .s_axi_awaddr_i(awaddr),
      .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
      .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
      .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
      .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
      .line_cond_i(cond), .level_code_i(lvl), .equalizer_gain_cap_i(eq_cap), .short_haul_i(short_haul),
      .line_standard_select_i(std_sel), .tx_build_out_code_i(tx_build_out_code), .rx_cfg_o(rx_cfg), .irq_o(irq));
   lif_line_model u_line (.clk_i(clk_i), .resetn_i(resetn_i), .cond_req_i(cond_req), .level_req_i(lvl_req),
      .cond_o(cond), .level_o(lvl));

   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   function automatic lif_rxcfg_t exp_cfg(input logic [7:0] v, input logic t1);
      lif_rxcfg_t e;
      logic [7:0] ohm [4] = '{8'h4B, 8'h64, 8'h6E, 8'h78};
      logic [5:0] gain [4] = '{6'h0E, 6'h14, 6'h1A, 6'h20};
      logic [6:0] lmon [4] = '{7'h3C, 7'h2D, 7'h23, 7'h18};
      logic [6:0] loff [4] = '{7'h18, 7'h24, 7'h3C, 7'h48};
      e.rx_clock_input_mode = v[7];
      e.clock_khz = t1 ? 12'h608 : 12'h800;
      e.termination_en = ~v[6];
      e.impedance_ohm = ohm[v[5:4]];
      e.turns_2to1 = v[3];
      e.rx_monitor_enable = v[2];
      e.monitor_gain_db = v[2] ? gain[v[1:0]] : 6'h00;
      e.max_loss_half_db = v[2] ? lmon[v[1:0]] : loff[v[1:0]];
      if (!v[2] && v[1:0] == 2'h3 && !t1) e.max_loss_half_db = 7'h56;
      return e;
   endfunction : exp_cfg

   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : print_verdict

   task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_val

   task automatic chk_cfg(input lif_rxcfg_t exp, input lif_rxcfg_t got);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] rx_cfg expected %h seen %h", exp, got);
      end
   endtask : chk_cfg

   // The master keeps each valid up until its own ready and bready until bvalid.
   task automatic axi_wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] exp_resp);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= {24'h00_0000, d};
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge clk_i);
         if (bvalid === 1'b1) break;
         if (awvalid && awready === 1'b1) awvalid <= 1'b0;
         if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      end
      chk_val("bresp", {30'h0, exp_resp}, {30'h0, bresp});
      bready <= 1'b0;
      // One idle edge keeps a following call from re-raising bready in the same step.
      @(posedge clk_i);
   endtask : axi_wr

   task automatic axi_rd(input logic [15:0] a, input logic [1:0] exp_resp, output logic [31:0] d);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge clk_i);
         if (rvalid === 1'b1) break;
         if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      end
      d = rdata;
      chk_val("rresp", {30'h0, exp_resp}, {30'h0, rresp});
      rready <= 1'b0;
      @(posedge clk_i);
   endtask : axi_rd

   task automatic rd_chk(input string what, input logic [15:0] a, input logic [7:0] exp);
      logic [31:0] d;
      axi_rd(a, LIF_RESP_OKAY, d);
      chk_val(what, {24'h00_0000, exp}, d);
   endtask : rd_chk

   task automatic chk_irq();
      repeat (2) @(posedge clk_i);
      chk_val("irq", {31'h0, |(m_lat & m_mask)}, {31'h0, irq});
   endtask : chk_irq

   // Onsets land in the low nibble and endings in the high one.
   task automatic set_cond(input logic [3:0] c);
      logic [3:0] rise, fall;
      rise = c & ~cond_req;
      fall = ~c & cond_req;
      if (std_sel && tx_build_out_code >= 3'h5) rise[2:1] = 2'b00;
      m_lat = m_lat | {fall, rise};
      cond_req <= c;
      repeat (3) @(posedge clk_i);
   endtask : set_cond

   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         error_cnt++;
         print_verdict();
      end
   end

   initial begin
      logic [31:0] r, d;
      logic [3:0] cap, raw;
      logic [7:0] v;
      seed = 32'h0000_0028;
      {error_cnt, compares, cycles} = '0;
      {m_lat, m_mask} = '0;
      {awvalid, wvalid, bready, arvalid, rready, short_haul, std_sel} <= '0;
      {awaddr, araddr, wdata, lvl_req, eq_cap, tx_build_out_code} <= '0;
      wstrb <= 4'h1;
      cond_req <= '0;
      resetn_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      resetn_i <= 1'b1;
      @(posedge clk_i);
      rd_chk("mask", A_MASK, 8'h00);
      rd_chk("latched", A_LAT, 8'h00);
      axi_wr(A_LVL, 8'hF0, LIF_RESP_OKAY);
      rd_chk("level", A_LVL, 8'h00);
      rd_chk("rxcfg", A_CFG, 8'h00);
      chk_cfg(exp_cfg(8'h00, 1'b0), rx_cfg);
      axi_rd(16'h4020, LIF_RESP_SLVERR, d);
      chk_val("slverr rdata", 32'h0000_0000, d);
      axi_wr(16'h4011, 8'hFF, LIF_RESP_SLVERR);
      // A write with byte lane 0 disabled is answered but stores nothing.
      wstrb <= 4'h0;
      axi_wr(A_MASK, 8'hFF, LIF_RESP_OKAY);
      wstrb <= 4'h1;
      rd_chk("mask", A_MASK, 8'h00);
      for (int p = 0; p < 2; p++) begin
         std_sel <= (p == 1);
         tx_build_out_code <= (p == 1) ? 3'h5 : 3'h0;
         r = xs();
         m_mask = r[7:0];
         axi_wr(A_MASK, m_mask, LIF_RESP_OKAY);
         rd_chk("mask", A_MASK, m_mask);
         chk_irq();
         for (int k = 0; k < 4; k++) begin
            set_cond(4'h1 << k);
            chk_irq();
            rd_chk("latched", A_LAT, m_lat);
            set_cond(4'h0);
            chk_irq();
            rd_chk("latched", A_LAT, m_lat);
         end
         r = xs();
         axi_wr(A_LAT, r[7:0], LIF_RESP_OKAY);
         m_lat = m_lat & ~r[7:0];
         chk_irq();
         rd_chk("latched", A_LAT, m_lat);
         axi_wr(A_LAT, 8'hFF, LIF_RESP_OKAY);
         m_lat = 8'h00;
         chk_irq();
      end
      for (int i = 0; i < 16; i++) begin
         r = xs();
         raw = (i < 3) ? 4'hF : r[3:0];
         lvl_req <= raw;
         eq_cap <= r[7:4];
         short_haul <= r[8];
         std_sel <= r[9];
         repeat (3) @(posedge clk_i);
         cap = r[9] ? 4'hD : 4'hF;
         if (r[8] && r[7:4] < cap) cap = r[7:4];
         if (raw < cap) cap = raw;
         rd_chk("level", A_LVL, {cap, 4'h0});
      end
      for (int i = 0; i < 16; i++) begin
         r = xs();
         v = {r[7:4], i[3:0]};
         // Software selects the 2:1 ratio only on short-haul lines.
         short_haul <= v[3];
         std_sel <= r[9];
         axi_wr(A_CFG, v, LIF_RESP_OKAY);
         rd_chk("rxcfg", A_CFG, v);
         chk_cfg(exp_cfg(v, r[9]), rx_cfg);
      end
      print_verdict();
   end
endmodule : testbench
